// ---- easc_pkg.sv ----
// constants shared by the configuration auto-load logic
package easc_pkg;

	localparam int          WORD_W          = 16;
	localparam int          IDX_W           = 6;
	localparam int          REG_W           = 8;
	localparam int          FIELD_W         = 3;
	localparam int          N_FIELDS        = 6;
	localparam int          N_GROUP_EN      = 5;

	// configuration memory word indices
	localparam logic [5:0]  WORD_CTRL       = 6'h10;
	localparam logic [5:0]  WORD_FIRST      = 6'h16;
	localparam logic [5:0]  WORD_LAST       = 6'h28;
	localparam logic [5:0]  WORD_P1_CTRL2   = 6'h16;
	localparam logic [5:0]  WORD_UP_CTRL1   = 6'h19;
	localparam logic [5:0]  WORD_UP_CTRL2   = 6'h1A;
	localparam logic [5:0]  WORD_P0_VLAN    = 6'h1B;
	localparam logic [5:0]  WORD_P1_VLAN    = 6'h1C;
	localparam logic [5:0]  WORD_UP_VLAN    = 6'h1E;
	localparam logic [5:0]  WORD_VLAN_PRI   = 6'h1F;
	localparam logic [5:0]  WORD_GROUP_LO   = 6'h20;
	localparam logic [5:0]  WORD_GROUP_HI   = 6'h27;
	localparam logic [5:0]  WORD_TOS0       = 6'h28;

	// image slots cover WORD_FIRST .. WORD_LAST
	localparam int          N_SLOTS         = 19;
	localparam int          SLOT_W          = 5;

	// enable fields of the control word, field k is bits 2k+1:2k
	localparam logic [1:0]  ENABLE_CODE     = 2'h1;
	localparam logic [2:0]  FIELD_PORTCTL   = 3'h1;
	localparam logic [2:0]  FIELD_VLANTAG   = 3'h2;
	localparam logic [2:0]  FIELD_VLANPRI   = 3'h3;
	localparam logic [2:0]  FIELD_GROUP     = 3'h4;
	localparam logic [2:0]  FIELD_TOS       = 3'h5;

	// port selects for per-port targets
	localparam logic [1:0]  PORT_0          = 2'h0;
	localparam logic [1:0]  PORT_1          = 2'h1;
	localparam logic [1:0]  PORT_CPU        = 2'h3;

	// target register addresses
	localparam logic [7:0]  REG_PORT_CTRL   = 8'h61;
	localparam logic [7:0]  REG_PORT_IOCTL  = 8'h66;
	localparam logic [7:0]  REG_PORT_BW     = 8'h67;
	localparam logic [7:0]  REG_PORT_BW_HI  = 8'h6D;
	localparam logic [7:0]  REG_VLAN_TAG_LO = 8'h6E;
	localparam logic [7:0]  REG_VLAN_TAG_HI = 8'h6F;
	localparam logic [7:0]  REG_VLAN_PRI_LO = 8'hD0;
	localparam logic [7:0]  REG_VLAN_PRI_HI = 8'hD1;
	localparam logic [7:0]  REG_GROUP_BASE  = 8'hB0;
	localparam logic [7:0]  REG_TOS0_LO     = 8'hC0;
	localparam logic [7:0]  REG_TOS0_HI     = 8'hC1;

	localparam logic [15:0] CTRL_RESET      = 16'h0000;

	typedef enum logic [2:0] {
		EASC_IDLE  = 3'h0,
		EASC_CTRL  = 3'h1,
		EASC_SCAN  = 3'h3,
		EASC_READ  = 3'h2,
		EASC_WRITE = 3'h6,
		EASC_DONE  = 3'h7
	} easc_state_t;

	typedef enum logic [1:0] {
		EASC_W_IDLE = 2'h0,
		EASC_W_LO   = 2'h1,
		EASC_W_HI   = 2'h3
	} easc_wstate_t;

endpackage

// ---- easc_word_map.sv ----
// lookup from configuration word index to its gating field and target registers
`timescale 1ns/1ns
`default_nettype none

module easc_word_map
	import easc_pkg::*;
(
	input  wire logic [5:0] i_word,
	output logic            o_hit,
	output logic [2:0]      o_field,
	output logic            o_per_port,
	output logic [1:0]      o_port,
	output logic [7:0]      o_lo_addr,
	output logic [7:0]      o_hi_addr
);

	logic [5:0] group_off;
	logic [2:0] group_n;

	assign group_off = i_word - WORD_GROUP_LO;
	assign group_n   = group_off[2:0];

	// reserved words fall to the default and are never hit
	always_comb begin
		o_hit      = 1'b1;
		o_field    = FIELD_PORTCTL;
		o_per_port = 1'b1;
		o_port     = PORT_0;
		o_lo_addr  = REG_PORT_CTRL;
		o_hi_addr  = REG_PORT_IOCTL;
		case (i_word)
			WORD_P1_CTRL2: begin
				o_port    = PORT_1;
				o_lo_addr = REG_PORT_BW;
				o_hi_addr = REG_PORT_BW_HI;
			end
			WORD_UP_CTRL1: begin
				o_port = PORT_CPU;
			end
			WORD_UP_CTRL2: begin
				o_port    = PORT_CPU;
				o_lo_addr = REG_PORT_BW;
				o_hi_addr = REG_PORT_BW_HI;
			end
			WORD_P0_VLAN, WORD_P1_VLAN, WORD_UP_VLAN: begin
				o_field   = FIELD_VLANTAG;
				o_lo_addr = REG_VLAN_TAG_LO;
				o_hi_addr = REG_VLAN_TAG_HI;
				if (i_word == WORD_P0_VLAN) begin
					o_port = PORT_0;
				end else if (i_word == WORD_P1_VLAN) begin
					o_port = PORT_1;
				end else begin
					o_port = PORT_CPU;
				end
			end
			WORD_VLAN_PRI: begin
				o_field    = FIELD_VLANPRI;
				o_per_port = 1'b0;
				o_lo_addr  = REG_VLAN_PRI_LO;
				o_hi_addr  = REG_VLAN_PRI_HI;
			end
			WORD_TOS0: begin
				o_field    = FIELD_TOS;
				o_per_port = 1'b0;
				o_lo_addr  = REG_TOS0_LO;
				o_hi_addr  = REG_TOS0_HI;
			end
			default: begin
				if (i_word >= WORD_GROUP_LO && i_word <= WORD_GROUP_HI) begin
					o_field    = FIELD_GROUP;
					o_per_port = 1'b0;
					o_lo_addr  = REG_GROUP_BASE | {4'h0, group_n, 1'b0};
					o_hi_addr  = REG_GROUP_BASE | {4'h0, group_n, 1'b1};
				end else begin
					o_hit = 1'b0;
				end
			end
		endcase
	end

endmodule
`default_nettype wire

// ---- easc_byte_writer.sv ----
// splits one accepted word into two byte writes, low byte first
`timescale 1ns/1ns
`default_nettype none

module easc_byte_writer
	import easc_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_start,
	input  wire logic [15:0] i_word,
	input  wire logic        i_per_port,
	input  wire logic [1:0]  i_port,
	input  wire logic [7:0]  i_lo_addr,
	input  wire logic [7:0]  i_hi_addr,
	input  wire logic        i_wr_ready,
	output logic             o_wr_en,
	output logic             o_wr_per_port,
	output logic [1:0]       o_wr_port,
	output logic [7:0]       o_wr_addr,
	output logic [7:0]       o_wr_data,
	output logic             o_done
);

	easc_wstate_t state_reg;
	easc_wstate_t state_next;
	logic [7:0]   addr_reg;
	logic [7:0]   addr_next;
	logic [7:0]   data_reg;
	logic [7:0]   data_next;
	logic [7:0]   hi_addr_reg;
	logic [7:0]   hi_addr_next;
	logic [7:0]   hi_data_reg;
	logic [7:0]   hi_data_next;
	logic         per_port_reg;
	logic         per_port_next;
	logic [1:0]   port_reg;
	logic [1:0]   port_next;

	always_comb begin
		state_next    = state_reg;
		addr_next     = addr_reg;
		data_next     = data_reg;
		hi_addr_next  = hi_addr_reg;
		hi_data_next  = hi_data_reg;
		per_port_next = per_port_reg;
		port_next     = port_reg;
		case (state_reg)
			EASC_W_IDLE: begin
				if (i_start) begin
					addr_next     = i_lo_addr;
					data_next     = i_word[7:0];
					hi_addr_next  = i_hi_addr;
					hi_data_next  = i_word[15:8];
					per_port_next = i_per_port;
					port_next     = i_port;
					state_next    = EASC_W_LO;
				end
			end
			EASC_W_LO: begin
				if (i_wr_ready) begin
					addr_next  = hi_addr_reg;
					data_next  = hi_data_reg;
					state_next = EASC_W_HI;
				end
			end
			EASC_W_HI: begin
				if (i_wr_ready) begin
					state_next = EASC_W_IDLE;
				end
			end
			default: begin
				state_next = EASC_W_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg    <= EASC_W_IDLE;
			addr_reg     <= 8'h00;
			data_reg     <= 8'h00;
			hi_addr_reg  <= 8'h00;
			hi_data_reg  <= 8'h00;
			per_port_reg <= 1'b0;
			port_reg     <= PORT_0;
		end else if (i_ce) begin
			state_reg    <= state_next;
			addr_reg     <= addr_next;
			data_reg     <= data_next;
			hi_addr_reg  <= hi_addr_next;
			hi_data_reg  <= hi_data_next;
			per_port_reg <= per_port_next;
			port_reg     <= port_next;
		end
	end

	assign o_wr_en       = (state_reg != EASC_W_IDLE);
	assign o_wr_per_port = per_port_reg;
	assign o_wr_port     = port_reg;
	assign o_wr_addr     = addr_reg;
	assign o_wr_data     = data_reg;
	assign o_done        = (state_reg == EASC_W_HI) && i_wr_ready && i_ce;

endmodule
`default_nettype wire

// ---- easc_loader.sv ----
// power-on auto-load of switch configuration words from the configuration memory
`timescale 1ns/1ns
`default_nettype none

module easc_loader
	import easc_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	// word read port toward the configuration memory access logic
	output logic             o_rd_req,
	output logic [5:0]       o_rd_addr,
	input  wire logic        i_rd_valid,
	input  wire logic [15:0] i_rd_data,
	// byte write port toward the switch register file
	output logic             o_wr_en,
	output logic             o_wr_per_port,
	output logic [1:0]       o_wr_port,
	output logic [7:0]       o_wr_addr,
	output logic [7:0]       o_wr_data,
	input  wire logic        i_wr_ready,
	// status
	output logic             o_busy,
	output logic             o_done,
	output logic [15:0]      o_ctrl_word,
	output logic [4:0]       o_group_en,
	output logic [4:0]       o_field_bad,
	output logic [4:0]       o_words_loaded,
	// readback of the loaded image
	input  wire logic [5:0]  i_peek_word,
	output logic [15:0]      o_peek_data,
	output logic             o_peek_valid
);

	// sequencer state, word cursor and read address
	easc_state_t       state_reg;
	easc_state_t       state_next;
	logic [5:0]        idx_reg;
	logic [5:0]        idx_next;
	logic [5:0]        rd_addr_reg;
	logic [5:0]        rd_addr_next;

	// captured control word and its decoded fields
	logic [15:0]       ctrl_reg;
	logic [15:0]       ctrl_next;
	logic [4:0]        group_en_reg;
	logic [4:0]        group_en_next;
	logic [4:0]        field_bad_reg;
	logic [4:0]        field_bad_next;

	// progress: words fully written and image slots filled
	logic [4:0]        count_reg;
	logic [4:0]        count_next;
	logic [N_SLOTS-1:0] loaded_reg;
	logic [N_SLOTS-1:0] loaded_next;

	// registered readback
	logic [15:0]       peek_data_reg;
	logic [15:0]       peek_data_next;
	logic              peek_valid_reg;
	logic              peek_valid_next;

	// image of every word that was accepted, kept for readback
	logic [15:0]       image_mem [N_SLOTS];
	logic              image_we;
	logic [SLOT_W-1:0] image_slot;
	logic [5:0]        image_off;

	// word map answers for the word under the cursor
	logic              map_hit;
	logic [2:0]        map_field;
	logic              map_per_port;
	logic [1:0]        map_port;
	logic [7:0]        map_lo_addr;
	logic [7:0]        map_hi_addr;

	logic [N_FIELDS-1:0] field_en_rd;
	logic [N_FIELDS-1:0] field_bad_rd;
	logic [N_FIELDS-1:0] field_en_all;
	logic              word_wanted;
	logic              wr_start;
	logic              wr_done;

	logic [5:0]        peek_off;
	logic [SLOT_W-1:0] peek_slot;
	logic              peek_in_range;

	// the map follows the cursor, so it is settled a cycle before the read
	easc_word_map u_word_map (
		.i_word     (idx_reg),
		.o_hit      (map_hit),
		.o_field    (map_field),
		.o_per_port (map_per_port),
		.o_port     (map_port),
		.o_lo_addr  (map_lo_addr),
		.o_hi_addr  (map_hi_addr)
	);

	// decode each enable field of the control word as it arrives
	genvar gf;
	generate
		for (gf = 0; gf < N_FIELDS; gf++) begin : g_field
			assign field_en_rd[gf]  = (i_rd_data[2*gf+1:2*gf] == ENABLE_CODE);
			// 00 is the common "off" value, anything else but 01 is flagged
			assign field_bad_rd[gf] = (i_rd_data[2*gf+1:2*gf] != ENABLE_CODE)
				&& (i_rd_data[2*gf+1:2*gf] != 2'h0);
		end
	endgenerate

	// field 0 gates words outside this loader, so it is held at zero here
	assign field_en_all = {group_en_reg, 1'b0};

	// a word is read only when it maps somewhere and its field says 01
	assign word_wanted = map_hit && field_en_all[map_field];

	// a read answer in READ hands the word to the byte writer
	assign wr_start = (state_reg == EASC_READ) && i_rd_valid;

	// slot of the word under the cursor in the image
	assign image_off  = idx_reg - WORD_FIRST;
	assign image_slot = image_off[SLOT_W-1:0];
	assign image_we   = wr_start && i_ce;

	// next-state logic of the load sequence
	always_comb begin
		state_next     = state_reg;
		idx_next       = idx_reg;
		rd_addr_next   = rd_addr_reg;
		ctrl_next      = ctrl_reg;
		group_en_next  = group_en_reg;
		field_bad_next = field_bad_reg;
		count_next     = count_reg;
		loaded_next    = loaded_reg;
		case (state_reg)
			EASC_IDLE: begin
				rd_addr_next = WORD_CTRL;
				state_next   = EASC_CTRL;
			end

			EASC_CTRL: begin
				// fields decode from the live data, so they land with the capture
				if (i_rd_valid) begin
					ctrl_next      = i_rd_data;
					group_en_next  = field_en_rd[N_FIELDS-1:1];
					field_bad_next = field_bad_rd[N_FIELDS-1:1];
					idx_next       = WORD_FIRST;
					state_next     = EASC_SCAN;
				end
			end

			EASC_SCAN: begin
				// one cycle per word, reserved and disabled ones are stepped over
				if (word_wanted) begin
					rd_addr_next = idx_reg;
					state_next   = EASC_READ;
				end else if (idx_reg == WORD_LAST) begin
					state_next = EASC_DONE;
				end else begin
					idx_next = idx_reg + 6'h01;
				end
			end

			EASC_READ: begin
				// the byte writer latches the word on this same edge
				if (i_rd_valid) begin
					loaded_next[image_slot] = 1'b1;
					state_next              = EASC_WRITE;
				end
			end

			EASC_WRITE: begin
				// the cursor moves only once both bytes are taken
				if (wr_done) begin
					count_next = count_reg + 5'h01;
					if (idx_reg == WORD_LAST) begin
						state_next = EASC_DONE;
					end else begin
						idx_next   = idx_reg + 6'h01;
						state_next = EASC_SCAN;
					end
				end
			end

			EASC_DONE: begin
				// stays here until the next reset so the load never repeats
				state_next = EASC_DONE;
			end

			default: begin
				state_next = EASC_IDLE;
			end
		endcase
	end

	// one register bank, frozen as a whole while the clock enable is low
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg     <= EASC_IDLE;
			idx_reg       <= WORD_FIRST;
			rd_addr_reg   <= WORD_CTRL;
			ctrl_reg      <= CTRL_RESET;
			group_en_reg  <= 5'h00;
			field_bad_reg <= 5'h00;
			count_reg     <= 5'h00;
			loaded_reg    <= '0;
		end else if (i_ce) begin
			state_reg     <= state_next;
			idx_reg       <= idx_next;
			rd_addr_reg   <= rd_addr_next;
			ctrl_reg      <= ctrl_next;
			group_en_reg  <= group_en_next;
			field_bad_reg <= field_bad_next;
			count_reg     <= count_next;
			loaded_reg    <= loaded_next;
		end
	end

	// image storage has no reset; the loaded flags qualify every readback
	always_ff @(posedge i_clock) begin
		if (image_we) begin
			image_mem[image_slot] <= i_rd_data;
		end
	end

	// the writer holds each byte until it is taken, which stalls the whole load
	easc_byte_writer u_byte_writer (
		.i_clock       (i_clock),
		.i_rst         (i_rst),
		.i_ce          (i_ce),
		.i_start       (wr_start),
		.i_word        (i_rd_data),
		.i_per_port    (map_per_port),
		.i_port        (map_port),
		.i_lo_addr     (map_lo_addr),
		.i_hi_addr     (map_hi_addr),
		.i_wr_ready    (i_wr_ready),
		.o_wr_en       (o_wr_en),
		.o_wr_per_port (o_wr_per_port),
		.o_wr_port     (o_wr_port),
		.o_wr_addr     (o_wr_addr),
		.o_wr_data     (o_wr_data),
		.o_done        (wr_done)
	);

	// words outside the image always read back as not loaded
	assign peek_off      = i_peek_word - WORD_FIRST;
	assign peek_slot     = peek_off[SLOT_W-1:0];
	assign peek_in_range = (i_peek_word >= WORD_FIRST) && (i_peek_word <= WORD_LAST);

	always_comb begin
		peek_data_next  = 16'h0000;
		peek_valid_next = 1'b0;
		if (peek_in_range && loaded_reg[peek_slot]) begin
			peek_data_next  = image_mem[peek_slot];
			peek_valid_next = 1'b1;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			peek_data_reg  <= 16'h0000;
			peek_valid_reg <= 1'b0;
		end else if (i_ce) begin
			peek_data_reg  <= peek_data_next;
			peek_valid_reg <= peek_valid_next;
		end
	end

	// request is a level held until the word comes back
	assign o_rd_req       = (state_reg == EASC_CTRL) || (state_reg == EASC_READ);
	assign o_rd_addr      = rd_addr_reg;

	// status comes straight from the registers
	assign o_busy         = (state_reg != EASC_DONE);
	assign o_done         = (state_reg == EASC_DONE);
	assign o_ctrl_word    = ctrl_reg;
	assign o_group_en     = group_en_reg;
	assign o_field_bad    = field_bad_reg;
	assign o_words_loaded = count_reg;
	assign o_peek_data    = peek_data_reg;
	assign o_peek_valid   = peek_valid_reg;

endmodule
`default_nettype wire

// ---- easc_loader_sva.sv ----
// concurrent checks on the auto-loader ports
`timescale 1ns/1ns
`default_nettype none

module easc_loader_sva (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        o_rd_req,
	input  wire logic [5:0]  o_rd_addr,
	input  wire logic        i_rd_valid,
	input  wire logic        o_wr_en,
	input  wire logic        o_wr_per_port,
	input  wire logic [1:0]  o_wr_port,
	input  wire logic [7:0]  o_wr_addr,
	input  wire logic [7:0]  o_wr_data,
	input  wire logic        i_wr_ready,
	input  wire logic        o_busy,
	input  wire logic        o_done,
	input  wire logic [15:0] o_ctrl_word,
	input  wire logic [4:0]  o_group_en,
	input  wire logic [4:0]  o_field_bad
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	logic       seen_reg;
	logic [5:0] last_reg;
	logic [4:0] en_exp;
	logic [4:0] bad_exp;
	logic       took_wr;

	assign took_wr = o_wr_en && i_wr_ready && i_ce;
	always_comb begin
		for (int k = 1; k < 6; k++) begin
			en_exp[k-1] = o_ctrl_word[2*k +: 2] == 2'h1;
			bad_exp[k-1] = o_ctrl_word[2*k+1];
		end
	end
	// remembers the last requested word so read order can be judged
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			seen_reg <= 1'b0;
			last_reg <= 6'h00;
		end else if (o_rd_req) begin
			seen_reg <= 1'b1;
			last_reg <= o_rd_addr;
		end
	end

	sequence s_lo(a); took_wr && o_wr_addr == a; endsequence
	sequence s_hi(b); o_wr_en && o_wr_addr == b && $stable(o_wr_port); endsequence
	property p_pair(a, b); s_lo(a) |=> s_hi(b); endproperty

	a_ctrl_first: assert property (o_rd_req && !seen_reg |-> o_rd_addr == 6'h10)
		else $error("first read is not the control word");
	a_read_rising: assert property ($rose(o_rd_req) && seen_reg |-> o_rd_addr > last_reg)
		else $error("word reads out of order");
	a_skip_reserved: assert property (o_rd_req |-> o_rd_addr <= 6'h28
		&& !(o_rd_addr inside {6'h17, 6'h18, 6'h1D}))
		else $error("reserved or out of range word read");
	a_rd_hold: assert property (o_rd_req && !(i_rd_valid && i_ce) |=> o_rd_req && $stable(o_rd_addr))
		else $error("read request dropped before answer");
	a_wr_hold: assert property (o_wr_en && !took_wr |=> o_wr_en
		&& $stable({o_wr_addr, o_wr_data, o_wr_port, o_wr_per_port}))
		else $error("write changed before acceptance");
	a_pair_ctrl: assert property (p_pair(8'h61, 8'h66)) else $error("61h not followed by 66h");
	a_pair_bw: assert property (p_pair(8'h67, 8'h6D)) else $error("67h not followed by 6Dh");
	a_pair_vlan: assert property (p_pair(8'h6E, 8'h6F)) else $error("6Eh not followed by 6Fh");
	a_pair_pri: assert property (p_pair(8'hD0, 8'hD1)) else $error("D0h not followed by D1h");
	a_pair_tos: assert property (p_pair(8'hC0, 8'hC1)) else $error("C0h not followed by C1h");
	a_group_pair: assert property (took_wr && o_wr_addr[7:4] == 4'hB && !o_wr_addr[0]
		|=> o_wr_en && o_wr_addr == $past(o_wr_addr) + 8'h01)
		else $error("group byte pair broken");
	a_group_gated: assert property (o_wr_en && o_wr_addr[7:4] == 4'hB |-> o_group_en[3]
		&& !o_wr_per_port)
		else $error("group write while disabled");
	a_vlan_gated: assert property (o_wr_en && o_wr_addr[7:1] == 7'h37 |-> o_group_en[1]
		&& o_wr_per_port)
		else $error("tag write while disabled");
	a_en_decode: assert property (o_done |-> o_group_en == en_exp && o_field_bad == bad_exp)
		else $error("enable field decode wrong");
	a_done_final: assert property (o_done |=> o_done && !o_busy && !o_rd_req && !o_wr_en)
		else $error("activity after load finished");
endmodule

bind easc_loader easc_loader_sva i_easc_loader_sva (.i_clock(i_clock), .i_rst(i_rst),
	.i_ce(i_ce), .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_rd_valid(i_rd_valid),
	.o_wr_en(o_wr_en), .o_wr_per_port(o_wr_per_port), .o_wr_port(o_wr_port),
	.o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .i_wr_ready(i_wr_ready), .o_busy(o_busy),
	.o_done(o_done), .o_ctrl_word(o_ctrl_word), .o_group_en(o_group_en),
	.o_field_bad(o_field_bad));
`default_nettype wire

// ---- easc_cfg_mem_model.sv ----
// behavioural configuration memory answering word reads after a set delay
`timescale 1ns/1ns
`default_nettype none

module easc_cfg_mem_model (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_ce,
	input  wire logic        i_rd_req,
	input  wire logic [5:0]  i_rd_addr,
	input  wire logic [3:0]  i_delay,
	output logic             o_rd_valid,
	output logic [15:0]      o_rd_data
);
	logic [15:0] mem [0:63];
	logic [3:0]  cnt_reg;
	logic        wait_low_reg;

	// data toggles outside an answer so a stale word can never pass as fresh
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rd_valid <= 1'b0;
			cnt_reg <= 4'h0;
			wait_low_reg <= 1'b0;
			o_rd_data <= 16'hA5A5;
		end else if (o_rd_valid) begin
			if (i_ce) begin
				o_rd_valid <= 1'b0;
				wait_low_reg <= 1'b1;
				o_rd_data <= ~o_rd_data;
			end
		end else if (wait_low_reg) begin
			o_rd_data <= ~o_rd_data;
			if (!i_rd_req) wait_low_reg <= 1'b0;
		end else if (i_rd_req && cnt_reg == i_delay) begin
			o_rd_valid <= 1'b1;
			o_rd_data <= mem[i_rd_addr];
			cnt_reg <= 4'h0;
		end else begin
			o_rd_data <= ~o_rd_data;
			if (i_rd_req) cnt_reg <= cnt_reg + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- easc_loader_tb.sv ----
// randomised self-checking bench for the configuration auto-loader
`timescale 1ns/1ns
`default_nettype none

module easc_loader_tb;
	logic        i_clock, i_rst, i_ce, i_wr_ready, o_rd_req, i_rd_valid, o_wr_en;
	logic        o_wr_per_port, o_busy, o_done, o_peek_valid, rnd_on;
	logic [1:0]  o_wr_port;
	logic [3:0]  mem_delay;
	logic [4:0]  o_group_en, o_field_bad, o_words_loaded;
	logic [5:0]  o_rd_addr, i_peek_word, rq[$], erq[$];
	logic [7:0]  o_wr_addr, o_wr_data;
	logic [15:0] i_rd_data, o_ctrl_word, o_peek_data, img[0:63];
	logic [18:0] wq[$], ewq[$];
	integer      seed = 32'h0000_3bb5, n_errors = 0, check_count = 0, cyc = 0;

	easc_loader i_easc_loader (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
		.o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_rd_valid(i_rd_valid),
		.i_rd_data(i_rd_data), .o_wr_en(o_wr_en), .o_wr_per_port(o_wr_per_port),
		.o_wr_port(o_wr_port), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
		.i_wr_ready(i_wr_ready), .o_busy(o_busy), .o_done(o_done), .o_ctrl_word(o_ctrl_word),
		.o_group_en(o_group_en), .o_field_bad(o_field_bad), .o_words_loaded(o_words_loaded),
		.i_peek_word(i_peek_word), .o_peek_data(o_peek_data), .o_peek_valid(o_peek_valid));
	easc_cfg_mem_model i_easc_cfg_mem_model (.i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce),
		.i_rd_req(o_rd_req), .i_rd_addr(o_rd_addr), .i_delay(mem_delay),
		.o_rd_valid(i_rd_valid), .o_rd_data(i_rd_data));

	initial begin
		i_clock = 1'b0;
		forever #4 i_clock = ~i_clock;
	end

	// {field, per_port, port, lo addr, hi addr}; field 0 marks a word never loaded
	function automatic logic [21:0] wmap(input int w);
		case (w)
			22: return {3'h1, 3'h5, 8'h67, 8'h6D};
			25: return {3'h1, 3'h7, 8'h61, 8'h66};
			26: return {3'h1, 3'h7, 8'h67, 8'h6D};
			27: return {3'h2, 3'h4, 8'h6E, 8'h6F};
			28: return {3'h2, 3'h5, 8'h6E, 8'h6F};
			30: return {3'h2, 3'h7, 8'h6E, 8'h6F};
			31: return {3'h3, 3'h0, 8'hD0, 8'hD1};
			40: return {3'h5, 3'h0, 8'hC0, 8'hC1};
			default: return (w >= 32 && w <= 39) ?
				{3'h4, 3'h0, 8'(8'hB0 + 2*(w-32)), 8'(8'hB1 + 2*(w-32))} : 22'h00_0000;
		endcase
	endfunction

	function automatic logic en(input logic [15:0] c, input logic [2:0] f);
		return f != 3'h0 && c[2*f +: 2] == 2'h1;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic do_reset;
		i_rst <= 1'b1;
		repeat (16) @(posedge i_clock);
		wq.delete();
		rq.delete();
		i_rst <= 1'b0;
	endtask

	// random enable gaps and write stalls; monitors log every accepted transfer
	always @(posedge i_clock) begin
		cyc++;
		i_ce <= rnd_on ? ($random(seed) % 8 != 0) : 1'b1;
		i_wr_ready <= rnd_on ? ($random(seed) % 3 != 0) : 1'b1;
		if (!i_rst && o_wr_en && i_wr_ready && i_ce)
			wq.push_back({o_wr_per_port, o_wr_port, o_wr_addr, o_wr_data});
		if (!i_rst && o_rd_req && i_rd_valid && i_ce) rq.push_back(o_rd_addr);
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end

	initial begin
		logic [21:0] m;
		logic [15:0] ctrl;
		logic [4:0]  ge, fb, nl;
		i_rst = 1'b1;
		i_ce = 1'b1;
		i_wr_ready = 1'b1;
		i_peek_word = 6'h00;
		mem_delay = 4'h0;
		rnd_on = 1'b0;
		for (int t = 0; t < 10; t++) begin
			case (t)
				0: ctrl = 16'h0555;
				1: ctrl = 16'h0000;
				2: ctrl = 16'hFAAA;
				3: ctrl = 16'h0FFF;
				4: ctrl = 16'hF554;
				default: ctrl = 16'($random(seed));
			endcase
			for (int w = 0; w < 64; w++) begin
				img[w] = (w == 16) ? ctrl : 16'($random(seed));
				i_easc_cfg_mem_model.mem[w] = img[w];
			end
			mem_delay <= (t < 2) ? 4'h0 : 4'($random(seed));
			rnd_on <= t > 0;
			do_reset;
			// a second reset mid-load must restart from the control word
			if (t == 5) begin
				repeat (40) @(posedge i_clock);
				do_reset;
			end
			chk(o_busy, 1'b1);
			for (int k = 0; k < 2000 && o_done !== 1'b1; k++) @(posedge i_clock);
			repeat (20) @(posedge i_clock);
			rnd_on <= 1'b0;
			erq = '{6'h10};
			ewq.delete();
			nl = 5'h00;
			for (int w = 22; w <= 40; w++) begin
				m = wmap(w);
				if (en(ctrl, m[21:19])) begin
					erq.push_back(6'(w));
					ewq.push_back({m[18:16], m[15:8], img[w][7:0]});
					ewq.push_back({m[18:16], m[7:0], img[w][15:8]});
					nl++;
				end
			end
			for (int k = 1; k < 6; k++) begin
				ge[k-1] = en(ctrl, 3'(k));
				fb[k-1] = ctrl[2*k+1];
			end
			chk(o_done, 1'b1);
			chk(o_busy, 1'b0);
			chk(o_ctrl_word, ctrl);
			chk(o_group_en, ge);
			chk(o_field_bad, fb);
			chk(o_words_loaded, nl);
			chk(rq.size(), erq.size());
			for (int k = 0; k < erq.size() && k < rq.size(); k++) chk(rq[k], erq[k]);
			chk(wq.size(), ewq.size());
			for (int k = 0; k < ewq.size() && k < wq.size(); k++) chk(wq[k], ewq[k]);
			for (int w = 22; w <= 40; w++) begin
				@(posedge i_clock);
				i_peek_word <= 6'(w);
				@(posedge i_clock);
				#1;
				m = wmap(w);
				chk(o_peek_valid, en(ctrl, m[21:19]));
				chk(o_peek_data, en(ctrl, m[21:19]) ? img[w] : 16'h0000);
			end
			$display("test %0d ctrl %h finished", t, ctrl);
		end
		end_of_test;
	end
endmodule
`default_nettype wire
